/* File: src/rtcal_consts.svh */
// Offsets, field positions, reset values and timing counts of the alarm control block
`ifndef RTCAL_CONSTS_SVH
`define RTCAL_CONSTS_SVH
`define RTCAL_OFS_CLOCK_CONTROL 3'h0
`define RTCAL_OFS_ALARM_CONTROL 3'h1
`define RTCAL_OFS_ALARM_TIME 3'h2
`define RTCAL_OFS_ALARM_DATE 3'h3
`define RTCAL_OFS_UNLOCK_KEY 3'h4
`define RTCAL_KEY_FIRST 32'haa996655
`define RTCAL_KEY_SECOND 32'h556699aa
`define RTCAL_CC_ENABLE 15
`define RTCAL_CC_IDLE_STOP 13
`define RTCAL_CC_CLKSEL_LO 9
`define RTCAL_CC_OUTSEL_LO 7
`define RTCAL_CC_RUNNING 6
`define RTCAL_CC_UNLOCK 3
`define RTCAL_CC_SYNC 2
`define RTCAL_CC_HALF_SECOND_FLAG 1
`define RTCAL_CC_OE 0
`define RTCAL_CC_CAL_LO 16
`define RTCAL_AC_ENABLE 15
`define RTCAL_AC_CHIME 14
`define RTCAL_AC_PIV 13
`define RTCAL_AC_SYNC 12
`define RTCAL_AC_MASK_LO 8
`define RTCAL_RESET_WORD 32'h00000000
`define RTCAL_CLK_HZ 200000000
`define RTCAL_RTC_HZ 32768
`define RTCAL_TICK_DIV (`RTCAL_CLK_HZ / `RTCAL_RTC_HZ)
`define RTCAL_HALF_TICKS 16384
`define RTCAL_SYNC_GUARD 32
`endif

/* File: src/rtcal_pkg.sv */
// Types shared by the alarm control block
package rtcal_pkg;
   typedef enum logic [3:0] {
      RTCAL_EVERY_HALF = 4'b0000,
      RTCAL_EVERY_SEC = 4'b0001,
      RTCAL_EVERY_10SEC = 4'b0010,
      RTCAL_EVERY_MIN = 4'b0011,
      RTCAL_EVERY_10MIN = 4'b0100,
      RTCAL_EVERY_HOUR = 4'b0101,
      RTCAL_EVERY_DAY = 4'b0110,
      RTCAL_EVERY_WEEK = 4'b0111,
      RTCAL_EVERY_MONTH = 4'b1000,
      RTCAL_EVERY_YEAR = 4'b1001
   } rtcal_interval_t;
   typedef enum logic [1:0] {
      RTCAL_OUT_ALARM = 2'b00,
      RTCAL_OUT_SECONDS = 2'b01,
      RTCAL_OUT_RTC = 2'b10,
      RTCAL_OUT_NONE = 2'b11
   } rtcal_outsel_t;
endpackage

/* File: src/rtcal_prescaler.sv */
// Half-second prescaler driven by an rtc-rate enable from a divider
`include "rtcal_consts.svh"
module rtcal_prescaler #(
   parameter int TICK_DIV = `RTCAL_TICK_DIV
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic run,
   input wire logic seconds_write,
   output logic rtc_tick,
   output logic half_tick,
   output logic half_flag,
   output logic near_rollover
);
   logic [12:0] div_cnt;
   logic [13:0] pre_cnt;
   wire div_end = (div_cnt == 13'(TICK_DIV - 1));
   wire pre_end = (pre_cnt == 14'(`RTCAL_HALF_TICKS - 1));

   always_ff @(posedge clk) begin
      if (srst || !run) begin
         div_cnt <= 13'h0;
      end else begin
         div_cnt <= div_end ? 13'h0 : div_cnt + 13'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         rtc_tick <= 1'b0;
         half_tick <= 1'b0;
         half_flag <= 1'b0;
         pre_cnt <= 14'h0;
         near_rollover <= 1'b0;
      end else begin
         rtc_tick <= run && div_end;
         half_tick <= run && div_end && pre_end && !seconds_write;
         near_rollover <= pre_cnt >= 14'(`RTCAL_HALF_TICKS - `RTCAL_SYNC_GUARD);
         if (seconds_write) begin
            pre_cnt <= 14'h0;
            half_flag <= 1'b0;
         end else if (run && div_end) begin
            pre_cnt <= pre_end ? 14'h0 : pre_cnt + 14'h1;
            if (pre_end) begin
               half_flag <= !half_flag;
            end
         end
      end
   end
endmodule

/* File: src/rtcal_alarm_control.sv */
// Real-time clock control and alarm unit with an Avalon-MM register slave
// What this block does
// - Enable writable only while write unlocked
// - Idle stop halts clock in idle
// - Unlock set only after key sequence
// - Half-second flag read-only, cleared by seconds write
// - Clock output driven only when enabled
// - Registers reset only at power-on
// - Alarm bits 31 to 16 read zero
// - Alarm events only while alarm enabled
// - Chime wraps repeat count 00 to ff
// - Without chime, count stops at zero
// - Pulse initial value writable only when disabled
// - Sync flag low only far from rollover
// - Interval field picks alarm period
// - February 29 yearly alarm every four years
// - Last alarm clears the alarm enable
// - Repeat count decrements on every event except at zero without chime
//
// Added by the designer: the register offsets and the Avalon-MM register port.
`include "rtcal_consts.svh"
module rtcal_alarm_control #(
   parameter int TICK_DIV = `RTCAL_TICK_DIV
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [2:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic cpu_idle,
   input wire logic seconds_write,
   input wire logic [31:0] cur_time,
   input wire logic [31:0] cur_date,
   output logic clock_out,
   output logic alarm_pulse,
   output logic alarm_irq
);
   import rtcal_pkg::*;

   logic [31:0] clock_control;
   logic [15:0] alarm_control;
   logic [31:0] alarm_time;
   logic [31:0] alarm_date;
   logic key_first_seen;
   logic key_armed;
   logic [31:0] next_rdata;
   logic interval_match;
   logic rtc_tick;
   logic half_tick;
   logic half_flag;
   logic near_rollover;

   wire [31:0] be_mask = {{8{byteenable[3]}}, {8{byteenable[2]}},
                          {8{byteenable[1]}}, {8{byteenable[0]}}};
   wire do_write = write && !waitrequest;
   wire wr_cc = do_write && (address == `RTCAL_OFS_CLOCK_CONTROL);
   wire wr_ac = do_write && (address == `RTCAL_OFS_ALARM_CONTROL);
   wire wr_at = do_write && (address == `RTCAL_OFS_ALARM_TIME);
   wire wr_ad = do_write && (address == `RTCAL_OFS_ALARM_DATE);
   wire wr_key = do_write && (address == `RTCAL_OFS_UNLOCK_KEY);
   wire [31:0] cc_merged = (clock_control & ~be_mask) | (writedata & be_mask);
   wire [15:0] ac_merged = (alarm_control & ~be_mask[15:0]) | (writedata[15:0] & be_mask[15:0]);

   wire mod_enable = clock_control[`RTCAL_CC_ENABLE];
   wire idle_stop = clock_control[`RTCAL_CC_IDLE_STOP];
   wire write_unlock = clock_control[`RTCAL_CC_UNLOCK];
   wire clock_output_enable = clock_control[`RTCAL_CC_OE];
   wire [1:0] output_source_select = clock_control[`RTCAL_CC_OUTSEL_LO +: 2];
   wire running = mod_enable && !(idle_stop && cpu_idle);
   wire alarm_enable = alarm_control[`RTCAL_AC_ENABLE];
   wire chime = alarm_control[`RTCAL_AC_CHIME];
   wire [3:0] alarm_interval = alarm_control[`RTCAL_AC_MASK_LO +: 4];
   wire [7:0] repeat_count = alarm_control[7:0];
   wire alarm_sync_flag = near_rollover;
   wire alarm_event = half_tick && alarm_enable && interval_match;
   // Set request may only land while a completed key sequence is pending
   wire unlock_req = wr_cc && cc_merged[`RTCAL_CC_UNLOCK] && !write_unlock;

   rtcal_prescaler #(
      .TICK_DIV(TICK_DIV)
   ) u_pre (
      .clk(clk),
      .srst(srst),
      .run(running),
      .seconds_write(seconds_write),
      .rtc_tick(rtc_tick),
      .half_tick(half_tick),
      .half_flag(half_flag),
      .near_rollover(near_rollover)
   );

   // Fields: hours 29:24, minutes 22:16, seconds 14:8; date year 31:24,
   // month 20:16, day 13:8, weekday 2:0
   wire sec_eq = cur_time[14:8] == alarm_time[14:8];
   wire sec_lo_eq = cur_time[11:8] == alarm_time[11:8];
   wire min_eq = cur_time[22:16] == alarm_time[22:16];
   wire min_lo_eq = cur_time[19:16] == alarm_time[19:16];
   wire hour_eq = cur_time[29:24] == alarm_time[29:24];
   wire wday_eq = cur_date[2:0] == alarm_date[2:0];
   wire day_eq = cur_date[13:8] == alarm_date[13:8];
   wire month_eq = cur_date[20:16] == alarm_date[20:16];
   // Events land on the whole-second edge except in the half-second mode
   wire whole_sec = !half_flag;
   wire hms_eq = whole_sec && sec_eq && min_eq && hour_eq;

   always_comb begin
      case (rtcal_interval_t'(alarm_interval))
         RTCAL_EVERY_HALF: interval_match = 1'b1;
         RTCAL_EVERY_SEC: interval_match = whole_sec;
         RTCAL_EVERY_10SEC: interval_match = whole_sec && sec_lo_eq;
         RTCAL_EVERY_MIN: interval_match = whole_sec && sec_eq;
         RTCAL_EVERY_10MIN: interval_match = whole_sec && sec_eq && min_lo_eq;
         RTCAL_EVERY_HOUR: interval_match = whole_sec && sec_eq && min_eq;
         RTCAL_EVERY_DAY: interval_match = hms_eq;
         RTCAL_EVERY_WEEK: interval_match = hms_eq && wday_eq;
         RTCAL_EVERY_MONTH: interval_match = hms_eq && day_eq;
         // Feb 29 exists only in leap years
         RTCAL_EVERY_YEAR: interval_match = hms_eq && day_eq && month_eq;
         default: interval_match = 1'b0;
      endcase
   end

   // Unlock key sequence: first key then second key arms one unlock
   // Key sequence arming
   always_ff @(posedge clk) begin
      if (srst) begin
         key_first_seen <= 1'b0;
         key_armed <= 1'b0;
      end else if (wr_key) begin
         key_first_seen <= writedata == `RTCAL_KEY_FIRST;
         key_armed <= key_first_seen && (writedata == `RTCAL_KEY_SECOND);
      end else if (do_write) begin
         key_first_seen <= 1'b0;
         key_armed <= unlock_req ? 1'b0 : key_armed;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         clock_control <= `RTCAL_RESET_WORD;
      end else begin
         if (wr_cc) begin
            clock_control[25:16] <= cc_merged[25:16];
            clock_control[`RTCAL_CC_IDLE_STOP] <= cc_merged[`RTCAL_CC_IDLE_STOP];
            clock_control[10:7] <= cc_merged[10:7];
            clock_control[`RTCAL_CC_OE] <= cc_merged[`RTCAL_CC_OE];
            if (write_unlock) begin
               clock_control[`RTCAL_CC_ENABLE] <= cc_merged[`RTCAL_CC_ENABLE];
            end
            if (!cc_merged[`RTCAL_CC_UNLOCK] || key_armed) begin
               clock_control[`RTCAL_CC_UNLOCK] <= cc_merged[`RTCAL_CC_UNLOCK];
            end
         end
         clock_control[`RTCAL_CC_RUNNING] <= running;
         clock_control[`RTCAL_CC_SYNC] <= near_rollover;
         clock_control[`RTCAL_CC_HALF_SECOND_FLAG] <= half_flag && !seconds_write;
      end
   end

   // Write lands first; an alarm event in the same cycle then acts on the written count and enable, but tests the old chime bit
   wire [15:0] ac_base = wr_ac ? ac_merged : alarm_control;
   wire ac_en = ac_base[`RTCAL_AC_ENABLE];
   wire [7:0] ac_cnt = ac_base[7:0];

   always_ff @(posedge clk) begin
      if (srst) begin
         alarm_control <= 16'(`RTCAL_RESET_WORD);
         alarm_pulse <= 1'b0;
         alarm_irq <= 1'b0;
      end else begin
         alarm_control[`RTCAL_AC_CHIME] <= ac_base[`RTCAL_AC_CHIME];
         alarm_control[11:8] <= ac_base[11:8];
         alarm_control[`RTCAL_AC_SYNC] <= near_rollover;
         alarm_irq <= alarm_event;
         if (wr_ac && !alarm_enable) begin
            alarm_pulse <= ac_merged[`RTCAL_AC_PIV];
         end else if (alarm_event) begin
            alarm_pulse <= !alarm_pulse;
         end
         alarm_control[`RTCAL_AC_PIV] <= 1'b0;
         if (alarm_event) begin
            if (ac_cnt != 8'h00 || chime) begin
               alarm_control[7:0] <= ac_cnt - 8'h01;
            end
            alarm_control[`RTCAL_AC_ENABLE] <= ac_en && !(ac_cnt == 8'h00 && !chime);
         end else begin
            alarm_control[7:0] <= ac_cnt;
            alarm_control[`RTCAL_AC_ENABLE] <= ac_en;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         alarm_time <= `RTCAL_RESET_WORD;
         alarm_date <= `RTCAL_RESET_WORD;
      end else begin
         if (wr_at) begin
            alarm_time <= (alarm_time & ~be_mask) | (writedata & be_mask);
         end
         if (wr_ad) begin
            alarm_date <= (alarm_date & ~be_mask) | (writedata & be_mask);
         end
      end
   end

   wire [31:0] ac_read = {16'h0000, alarm_control[15:14], alarm_pulse,
                          alarm_sync_flag, alarm_control[11:0]};
   always_comb begin
      case (address)
         `RTCAL_OFS_CLOCK_CONTROL: next_rdata = clock_control;
         `RTCAL_OFS_ALARM_CONTROL: next_rdata = ac_read;
         `RTCAL_OFS_ALARM_TIME: next_rdata = alarm_time;
         `RTCAL_OFS_ALARM_DATE: next_rdata = alarm_date;
         default: next_rdata = 32'h00000000;
      endcase
   end

   // One wait cycle per access; data registered with the low waitrequest
   always_ff @(posedge clk) begin
      if (srst) begin
         waitrequest <= 1'b1;
         readdata <= 32'h00000000;
      end else begin
         waitrequest <= !((read || write) && waitrequest);
         if (read && waitrequest) begin
            readdata <= next_rdata;
         end
      end
   end

   wire [1:0] sel_src = output_source_select;
   wire src_bit = (sel_src == RTCAL_OUT_ALARM) ? alarm_pulse :
                  (sel_src == RTCAL_OUT_SECONDS) ? half_flag :
                  (sel_src == RTCAL_OUT_RTC) ? rtc_tick : 1'b0;
   always_ff @(posedge clk) begin
      if (srst) begin
         clock_out <= 1'b0;
      end else begin
         clock_out <= clock_output_enable && src_bit;
      end
   end

   unlock_gate_a: assert property (@(posedge clk) disable iff (srst)
      wr_cc && !write_unlock |=> $stable(clock_control[`RTCAL_CC_ENABLE]))
      else $error("enable changed while locked");
   unlock_key_a: assert property (@(posedge clk) disable iff (srst)
      $rose(clock_control[`RTCAL_CC_UNLOCK]) |-> $past(key_armed) && $past(wr_cc))
      else $error("unlock set without key sequence");
   idle_halt_a: assert property (@(posedge clk) disable iff (srst)
      idle_stop && cpu_idle |=> !rtc_tick)
      else $error("prescaler ran in idle stop");
   half_second_flag_clear_a: assert property (@(posedge clk) disable iff (srst)
      seconds_write |=> !clock_control[`RTCAL_CC_HALF_SECOND_FLAG])
      else $error("half second flag not cleared");
   out_gate_a: assert property (@(posedge clk) disable iff (srst)
      !clock_output_enable |=> !clock_out)
      else $error("clock output active while disabled");
   upper_zero_a: assert property (@(posedge clk) disable iff (srst)
      address == `RTCAL_OFS_ALARM_CONTROL && read && waitrequest |=> readdata[31:16] == 16'h0000)
      else $error("alarm upper bits nonzero");
   event_gate_a: assert property (@(posedge clk) disable iff (srst)
      alarm_irq |-> $past(alarm_enable) && $past(half_tick))
      else $error("alarm event while disabled");
   chime_wrap_a: assert property (@(posedge clk) disable iff (srst)
      alarm_event && chime && !wr_ac && repeat_count == 8'h00 |=> repeat_count == 8'hff)
      else $error("chime did not wrap");
   count_stop_a: assert property (@(posedge clk) disable iff (srst)
      alarm_event && !chime && !wr_ac && repeat_count == 8'h00 |=> repeat_count == 8'h00)
      else $error("count moved below zero");
   count_dec_a: assert property (@(posedge clk) disable iff (srst)
      alarm_event && !wr_ac && repeat_count != 8'h00 |=> repeat_count == $past(repeat_count) - 8'h01)
      else $error("count did not decrement");
   last_clear_a: assert property (@(posedge clk) disable iff (srst)
      alarm_event && !wr_ac && !chime && repeat_count == 8'h00 |=> !alarm_enable ##1 !alarm_irq)
      else $error("enable not cleared on last alarm");
   pulse_toggle_a: assert property (@(posedge clk) disable iff (srst)
      alarm_event && !wr_ac |=> alarm_pulse != $past(alarm_pulse) && alarm_irq)
      else $error("pulse did not toggle");
   sync_flag_a: assert property (@(posedge clk) disable iff (srst)
      !near_rollover |-> !half_tick [*2])
      else $error("rollover inside quiet window");
endmodule

/* File: sim/testbench.sv */
// Self-checking bench for the alarm control block over its register bus
`include "rtcal_consts.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   // A one-clock rtc tick keeps each half second short enough to run several
   localparam int TICK_DIV = 1;
   localparam int HALF_CLKS = `RTCAL_HALF_TICKS * TICK_DIV;
   localparam int GUARD_CLKS = `RTCAL_SYNC_GUARD * TICK_DIV;
   localparam logic [2:0] ofs_cc = `RTCAL_OFS_CLOCK_CONTROL;
   localparam logic [2:0] ofs_ac = `RTCAL_OFS_ALARM_CONTROL;
   localparam logic [2:0] ofs_key = `RTCAL_OFS_UNLOCK_KEY;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [2:0] address = 3'h0;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [3:0] byteenable = 4'hf;
   logic cpu_idle = 1'b0;
   logic seconds_write = 1'b0;
   logic [31:0] cur_time = 32'h0;
   logic [31:0] cur_date = 32'h0;
   logic [31:0] readdata;
   logic waitrequest;
   logic clock_out;
   logic alarm_pulse;
   logic alarm_irq;
   logic [31:0] rd;
   int num_errors = 0;
   int checks_done = 0;
   int cnt;
   int k;

   rtcal_alarm_control #(.TICK_DIV(TICK_DIV)) i_dut (
      .clk(clk),
      .srst(srst),
      .address(address),
      .read(read),
      .write(write),
      .writedata(writedata),
      .byteenable(byteenable),
      .readdata(readdata),
      .waitrequest(waitrequest),
      .cpu_idle(cpu_idle),
      .seconds_write(seconds_write),
      .cur_time(cur_time),
      .cur_date(cur_date),
      .clock_out(clock_out),
      .alarm_pulse(alarm_pulse),
      .alarm_irq(alarm_irq)
   );

   always #2.5 clk = ~clk;

   task automatic final_report();
      $display("checks=%0d errors=%0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic timeout();
      num_errors++;
      $display("BAD t=%0t wait limit got=%h exp=%h", $time, 1'b0, 1'b1);
      final_report();
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Request stays up until the edge that sees waitrequest low
   task automatic bus_done();
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 50);
      if (n >= 50) timeout();
   endtask

   task automatic bus_write(input logic [2:0] a, input logic [31:0] d);
      @(posedge clk);
      address <= a;
      writedata <= d;
      write <= 1'b1;
      bus_done();
      write <= 1'b0;
   endtask

   task automatic bus_read(input logic [2:0] a, output logic [31:0] d);
      @(posedge clk);
      address <= a;
      read <= 1'b1;
      bus_done();
      d = readdata;
      read <= 1'b0;
   endtask

   // Irq is a one-cycle pulse, so it is looked at every cycle
   task automatic wait_irq(output int n);
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (alarm_irq !== 1'b1 && n < 2 * HALF_CLKS);
      if (alarm_irq !== 1'b1) timeout();
   endtask

   task automatic poll(input logic [2:0] a, input int b);
      k = 0;
      do begin
         bus_read(a, rd);
         k++;
      end while (rd[b] !== 1'b1 && k < HALF_CLKS / 2);
      if (rd[b] !== 1'b1) timeout();
   endtask

   // Count bits may move near a rollover, so reread until two reads agree
   task automatic read_agree(input logic [2:0] a, output logic [31:0] d);
      logic [31:0] prev;
      int n;
      n = 0;
      bus_read(a, d);
      do begin
         prev = d;
         bus_read(a, d);
         n++;
      end while (d !== prev && n < 8);
      if (d !== prev) timeout();
   endtask

   initial begin
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         bus_read(3'(i), rd);
         chk(rd, 32'h0);
      end
      // Locked: enable and unlock refuse, status bits ignore writes
      bus_write(ofs_cc, 32'hffffffff);
      bus_read(ofs_cc, rd);
      chk(rd, 32'h03ff2781);
      bus_write(ofs_ac, 32'h00002000);
      bus_read(ofs_ac, rd);
      chk(rd, 32'h00002000);
      chk({31'h0, alarm_pulse}, 32'h1);
      bus_write(ofs_cc, 32'h0);
      bus_read(ofs_cc, rd);
      chk({31'h0, clock_out}, 32'h0);
      for (int i = 0; i < 16; i++) begin
         bus_write(ofs_ac, 32'h00002000 | (i << 8));
         bus_read(ofs_ac, rd);
         chk(rd, 32'h00002000 | (i << 8));
      end
      bus_write(ofs_key, `RTCAL_KEY_FIRST);
      bus_write(ofs_key, `RTCAL_KEY_SECOND);
      bus_write(ofs_cc, 32'h00000008);
      bus_read(ofs_cc, rd);
      chk(rd, 32'h00000008);
      bus_write(ofs_cc, 32'h00008009);
      bus_read(ofs_cc, rd);
      chk(rd, 32'h00008049);
      chk({31'h0, clock_out}, 32'h1);
      bus_write(ofs_cc, 32'h00008001);
      bus_write(ofs_cc, 32'h00000001);
      bus_read(ofs_cc, rd);
      chk(rd, 32'h00008041);
      // One repeat, no chime: two events, then the alarm switches itself off
      bus_write(ofs_ac, 32'hffffa001);
      bus_read(ofs_ac, rd);
      chk(rd, 32'h0000a001);
      poll(ofs_ac, `RTCAL_AC_SYNC);
      wait_irq(cnt);
      chk({31'h0, cnt >= GUARD_CLKS - 8 && cnt <= GUARD_CLKS + 4}, 32'h1);
      bus_read(ofs_ac, rd);
      chk(rd, 32'h00008000);
      chk({31'h0, alarm_pulse}, 32'h0);
      wait_irq(cnt);
      bus_read(ofs_ac, rd);
      chk(rd, 32'h00002000);
      chk({31'h0, alarm_pulse}, 32'h1);
      cnt = 0;
      repeat (HALF_CLKS + 64) begin
         @(posedge clk);
         #1;
         if (alarm_irq === 1'b1) cnt++;
      end
      chk(cnt, 32'h0);
      // Chime from zero wraps the count and keeps the alarm on
      bus_read(ofs_ac, rd);
      chk({31'h0, rd[`RTCAL_AC_SYNC]}, 32'h0);
      bus_write(ofs_ac, 32'h0000e000);
      wait_irq(cnt);
      read_agree(ofs_ac, rd);
      chk(rd, 32'h0000c0ff);
      poll(ofs_cc, `RTCAL_CC_HALF_SECOND_FLAG);
      @(posedge clk);
      seconds_write <= 1'b1;
      @(posedge clk);
      seconds_write <= 1'b0;
      bus_read(ofs_cc, rd);
      chk(rd, 32'h00008041);
      // Idle only stops the clock when idle stop is set
      cpu_idle <= 1'b1;
      bus_read(ofs_cc, rd);
      chk(rd, 32'h00008041);
      bus_write(ofs_cc, 32'h00002001);
      repeat (200) @(posedge clk);
      bus_read(ofs_cc, rd);
      chk(rd, 32'h0000a001);
      cpu_idle <= 1'b0;
      bus_read(ofs_cc, rd);
      chk(rd, 32'h0000a041);
      final_report();
   end
endmodule
